// file: shared/dimgr_pkg.sv
//----------------------------------------------------------------------
// Purpose : Shared constants and types for the discrete I/O manager
// Assumes : 100 MHz system clock, 24 field inputs, 12 relay drivers
// Notes   : Input indices are zero based (input one is index 0)
//----------------------------------------------------------------------
package dimgr_pkg;

  // ********************************************************************
  // Sizes
  // ********************************************************************
  localparam int NUM_IN      = 24;
  localparam int NUM_CFG_IN  = 21;  // Inputs four to twenty-four
  localparam int NUM_OUT     = 12;
  localparam int NUM_SEL_OUT = 10;
  localparam int NUM_CTRL_FN = 30;  // Preprogrammed sources 1..30
  localparam int NUM_FIXED   = 3;   // Inputs with dedicated duty

  // ********************************************************************
  // Default input positions
  // ********************************************************************
  localparam int IDX_SHUTDOWN = 0;
  localparam int IDX_START    = 1;
  localparam int IDX_RESET    = 2;
  localparam int IDX_ACK      = 3;
  localparam int IDX_RATED    = 8;
  localparam int IDX_FUEL     = 10;
  localparam int IDX_GENBRK   = 13;
  localparam int IDX_UTILBRK  = 14;
  localparam int IDX_CUST_RW  = 20;  // Remote writes 21..24 feed relays

  // Remote contributions kept across a link loss
  localparam logic [NUM_IN-1:0] HOLD_MASK = 24'h000403;

  // ********************************************************************
  // Function codes for inputs four to twenty-four
  // ********************************************************************
  localparam logic [1:0] FN_DEFAULT    = 2'h0;
  localparam logic [1:0] FN_PERMISSIVE = 2'h1;
  localparam logic [1:0] FN_ALARM      = 2'h2;
  localparam logic [1:0] FN_SHUTDOWN   = 2'h3;

  // Relay source selector range
  localparam logic [5:0] SEL_CUST_FIRST = 6'h1f;
  localparam logic [5:0] SEL_CUST_LAST  = 6'h22;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int CLK_HZ       = 100_000_000;
  localparam int RATE_FAST_MS = 10;
  localparam int RATE_MID_MS  = 40;
  localparam int RATE_SLOW_MS = 160;
  localparam int FAST_CYC     = CLK_HZ / 1000 * RATE_FAST_MS;
  localparam int MID_DIV      = RATE_MID_MS / RATE_FAST_MS;
  localparam int SLOW_DIV     = RATE_SLOW_MS / RATE_FAST_MS;
  localparam int TICK_W       = 20;
  localparam int GRP_W        = 4;

  // Reset values
  localparam logic [NUM_IN-1:0]  IN_RST    = 24'h000000;
  localparam logic [NUM_OUT-1:0] RELAY_RST = 12'h000;

  // Alarm horn states
  typedef enum logic [1:0] {
    HORN_QUIET = 2'b01,
    HORN_SOUND = 2'b10
  } dimgr_horn_t;

  // Decoded commands toward the fuel control
  typedef struct packed {
    logic fuel_off;
    logic start_run;
    logic sys_reset;
    logic sys_ack;
    logic liquid_fuel;
    logic rated_hold;
    logic baseload;
    logic load_share_en;
    logic permissive_ok;
    logic alarm_any;
    logic shutdown_any;
  } dimgr_cmd_t;

endpackage : dimgr_pkg

// file: rtl/dimgr_top.sv
//----------------------------------------------------------------------
// Purpose : Discrete input conditioning and relay driver outputs
// Assumes : Field pins asynchronous; config and remote values on clock
// Notes   : Relay groups refresh on 10/40/160 ms enables
//----------------------------------------------------------------------
// Operation
// - Accept twenty-four sampled discrete field inputs
// - Customer use of inputs 1-3 drops duty
// - Publish state of every input for readback
// - Inputs 4-24 configurable: permissive, alarm, shutdown
// - Effective input is field OR enabled remote
// - Link loss: hold three remotes, clear others
// - Polarity of each input configurable; function of inputs 4-24
// - Input1 inactive commands fuel off; input2 starts
// - Input3 resets, input4 acknowledges alarms
// - Fuel select active liquid, inactive gas
// - Rated hold, or baseload with breaker closed
// - Utility breaker open enables load sharing
// - Provide twelve relay driver outputs
// - Relay1 energized while healthy without shutdown
// - Other relays rest de-energized until driven
// - Summary mode: alarm relay follows any alarm
// - Horn mode: set on event, clear on ack
// - Ten relays pick source via selector
// - Selections 31-34 drive remote customer values
// - Relays 1-6 10ms, 7-9 40ms, 10-12 160ms
`timescale 1ns/1ps

module dimgr_top
  import dimgr_pkg::*;
#(
  parameter int TICK_CYC = FAST_CYC
)(
  input  wire logic                          clock,
  input  wire logic                          nrst,
  input  wire logic [NUM_IN-1:0]             field_in,
  input  wire logic [NUM_IN-1:0]             pol_high,
  input  wire logic [NUM_IN-1:0]             remote_val,
  input  wire logic [NUM_IN-1:0]             remote_en,
  input  wire logic                          link_ok,
  input  wire logic [NUM_FIXED-1:0]          cust_use,
  input  wire logic [NUM_CFG_IN-1:0][1:0]    fn_sel,
  input  wire logic                          horn_mode,
  input  wire logic [NUM_SEL_OUT-1:0][5:0]   out_sel,
  input  wire logic [NUM_CTRL_FN-1:0]        ctrl_func,
  input  wire logic                          ctrl_healthy,
  input  wire logic                          ctrl_shutdown,
  input  wire logic                          ctrl_alarm,
  output logic      [NUM_IN-1:0]             in_status,
  output dimgr_cmd_t                         cmd,
  output logic      [NUM_OUT-1:0]            relay_out
);

  // ********************************************************************
  // Declarations
  // ********************************************************************
  logic [NUM_IN-1:0]  sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
  logic [NUM_IN-1:0]  rem_ff, nxt_rem;
  logic [NUM_IN-1:0]  eff_ff, nxt_eff;
  logic [NUM_IN-1:0]  field_act;
  logic [NUM_CFG_IN:0] alm_vec;
  logic [NUM_CFG_IN:0] alm_prev_ff, nxt_alm_prev;
  dimgr_horn_t        horn_ff, nxt_horn;
  logic [TICK_W-1:0]  tick_cnt_ff, nxt_tick_cnt;
  logic [GRP_W-1:0]   grp_cnt_ff, nxt_grp_cnt;
  logic               tick_fast, tick_mid, tick_slow;
  logic [NUM_OUT-1:0] relay_ff, nxt_relay;
  logic [NUM_OUT-1:0] relay_want;
  logic [63:0]        src_vec;
  logic               new_alarm;
  logic               alarm_drv;
  logic               perm_ok, in_alarm, in_shut;
  logic [NUM_IN-1:0]  dflt_eff;
  dimgr_cmd_t         cmd_c;

  // ********************************************************************
  // Field synchronizer
  // ********************************************************************
  // Two stages before any logic looks at a pin
  always_comb
  begin
    nxt_sync1 = field_in;
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_ff <= IN_RST;
      sync2_ff <= IN_RST;
    end
    else
    begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  // ********************************************************************
  // Remote contributions and effective input state
  // ********************************************************************
  // Polarity fold, then OR with the latched remote value
  always_comb
  begin
    field_act = ~(sync2_ff ^ pol_high);
    if (link_ok)
      nxt_rem = remote_val & remote_en;
    else
      nxt_rem = rem_ff & HOLD_MASK;
    nxt_eff = field_act | rem_ff;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rem_ff <= IN_RST;
      eff_ff <= IN_RST;
    end
    else
    begin
      rem_ff <= nxt_rem;
      eff_ff <= nxt_eff;
    end
  end

  assign in_status = eff_ff;

  // ********************************************************************
  // Function decode
  // ********************************************************************
  // Configurable inputs fold into sums; a coded input loses its named duty
  always_comb
  begin
    perm_ok  = 1'b1;
    in_alarm = 1'b0;
    in_shut  = 1'b0;
    dflt_eff = eff_ff;
    for (int i = 0; i < NUM_CFG_IN; i++)
    begin
      case (fn_sel[i])
        FN_PERMISSIVE: perm_ok  = perm_ok & eff_ff[i+NUM_FIXED];
        FN_ALARM:      in_alarm = in_alarm | eff_ff[i+NUM_FIXED];
        FN_SHUTDOWN:   in_shut  = in_shut | eff_ff[i+NUM_FIXED];
        default:       ;
      endcase
      if (fn_sel[i] != FN_DEFAULT)
        dflt_eff[i+NUM_FIXED] = 1'b0;
    end
  end

  // Dedicated duties drop out when an input is given to the customer
  always_comb
  begin
    cmd_c               = '0;
    cmd_c.fuel_off      = !cust_use[IDX_SHUTDOWN] && !eff_ff[IDX_SHUTDOWN];
    cmd_c.start_run     = !cust_use[IDX_START] && eff_ff[IDX_START];
    cmd_c.sys_reset     = !cust_use[IDX_RESET] && eff_ff[IDX_RESET];
    cmd_c.sys_ack       = dflt_eff[IDX_ACK];
    cmd_c.liquid_fuel   = dflt_eff[IDX_FUEL];
    cmd_c.rated_hold    = dflt_eff[IDX_RATED] && !dflt_eff[IDX_GENBRK];
    cmd_c.baseload      = dflt_eff[IDX_RATED] && dflt_eff[IDX_GENBRK];
    cmd_c.load_share_en = dflt_eff[IDX_UTILBRK];
    cmd_c.permissive_ok = perm_ok;
    cmd_c.alarm_any     = in_alarm | ctrl_alarm;
    cmd_c.shutdown_any  = in_shut | ctrl_shutdown | cmd_c.fuel_off;
  end

  assign cmd = cmd_c;

  // ********************************************************************
  // Alarm horn
  // ********************************************************************
  // A new event is any alarm source rising; set beats acknowledge
  // A process, not a function call, so input changes re-evaluate it
  always_comb
  begin
    alm_vec[NUM_CFG_IN] = ctrl_alarm;
    for (int i = 0; i < NUM_CFG_IN; i++)
      alm_vec[i] = (fn_sel[i] == FN_ALARM) && eff_ff[i+NUM_FIXED];
  end

  assign new_alarm = |(alm_vec & ~alm_prev_ff);

  always_comb
  begin
    nxt_alm_prev = alm_vec;
    case (horn_ff)
      HORN_QUIET: nxt_horn = new_alarm ? HORN_SOUND : HORN_QUIET;
      HORN_SOUND: nxt_horn = (cmd_c.sys_ack && !new_alarm) ? HORN_QUIET
                                                           : HORN_SOUND;
      default:    nxt_horn = HORN_QUIET;
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      alm_prev_ff <= '0;
      horn_ff     <= HORN_QUIET;
    end
    else
    begin
      alm_prev_ff <= nxt_alm_prev;
      horn_ff     <= nxt_horn;
    end
  end

  // Summary mode tracks the level, horn mode the latched event
  assign alarm_drv = horn_mode ? (horn_ff == HORN_SOUND) : cmd_c.alarm_any;

  // ********************************************************************
  // Rate group divider
  // ********************************************************************
  // One 10 ms enable; slower groups ride on a count of those
  assign tick_fast = (tick_cnt_ff == TICK_W'(TICK_CYC - 1));
  assign tick_mid  = tick_fast && (grp_cnt_ff[1:0] == 2'(MID_DIV - 1));
  assign tick_slow = tick_fast && (grp_cnt_ff == GRP_W'(SLOW_DIV - 1));

  always_comb
  begin
    nxt_tick_cnt = tick_fast ? '0 : tick_cnt_ff + 1'b1;
    nxt_grp_cnt  = tick_fast ? grp_cnt_ff + 1'b1 : grp_cnt_ff;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      tick_cnt_ff <= '0;
      grp_cnt_ff  <= '0;
    end
    else
    begin
      tick_cnt_ff <= nxt_tick_cnt;
      grp_cnt_ff  <= nxt_grp_cnt;
    end
  end

  // ********************************************************************
  // Relay drivers
  // ********************************************************************
  // Source table: code 0 and codes past 34 drive nothing
  always_comb
  begin
    src_vec = '0;
    src_vec[NUM_CTRL_FN:1] = ctrl_func;
    src_vec[SEL_CUST_LAST:SEL_CUST_FIRST] = rem_ff[IDX_CUST_RW +: 4];
    relay_want    = '0;
    relay_want[0] = ctrl_healthy && !cmd_c.shutdown_any;
    relay_want[1] = alarm_drv;
    for (int k = 0; k < NUM_SEL_OUT; k++)
      relay_want[k+2] = src_vec[out_sel[k]];
  end

  // Each group only moves on its own enable
  always_comb
  begin
    nxt_relay = relay_ff;
    if (tick_fast)
      nxt_relay[5:0] = relay_want[5:0];
    if (tick_mid)
      nxt_relay[8:6] = relay_want[8:6];
    if (tick_slow)
      nxt_relay[11:9] = relay_want[11:9];
  end

  // Fail safe: all de-energized until the first refresh
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      relay_ff <= RELAY_RST;
    else
      relay_ff <= nxt_relay;
  end

  assign relay_out = relay_ff;

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  AST_SYNC_TWO: assert property (
    ##2 sync2_ff == $past(field_in, 2))
    else $error("synchronizer depth is not two");

  AST_LINK_CLEAR: assert property (
    !link_ok |=> (rem_ff & ~HOLD_MASK) == '0)
    else $error("remote value survived link loss");

  AST_LINK_HOLD: assert property (
    (!link_ok && !$past(!link_ok)) ##1 !link_ok |-> (rem_ff & HOLD_MASK) == $past(rem_ff & HOLD_MASK))
    else $error("held remote value changed while link down");

  AST_REMOTE_OR: assert property (
    (rem_ff != '0) |=> (in_status & $past(rem_ff)) == $past(rem_ff))
    else $error("remote write not ORed into input");

  AST_FUEL_OFF: assert property (
    (!cust_use[IDX_SHUTDOWN] && !in_status[IDX_SHUTDOWN]) |-> cmd.fuel_off && cmd.shutdown_any)
    else $error("shutdown input lost without fuel off");

  AST_DEDICATED: assert property (
    cust_use[IDX_START] |-> !cmd.start_run)
    else $error("start duty still active after reassignment");

  AST_SUMMARY: assert property (
    (!horn_mode && cmd.alarm_any && tick_fast) |=> relay_out[1])
    else $error("summary alarm relay not set");

  AST_HORN_ACK: assert property (
    (horn_ff == HORN_SOUND && cmd.sys_ack && !new_alarm) |=> horn_ff == HORN_QUIET)
    else $error("horn not silenced by acknowledge");

  AST_FAST_STILL: assert property (
    !tick_fast |=> $stable(relay_out[5:0]))
    else $error("fast relays moved between refreshes");

  AST_MID_STILL: assert property (
    !tick_mid |=> $stable(relay_out[8:6]))
    else $error("mid relays moved between refreshes");

  AST_SHUT_RELAY: assert property (
    tick_fast |=> relay_out[0] == $past(ctrl_healthy && !cmd.shutdown_any))
    else $error("shutdown relay wrong after refresh");

  AST_CUST_SRC: assert property (
    (tick_fast && out_sel[0] == SEL_CUST_FIRST) |=> relay_out[2] == $past(rem_ff[IDX_CUST_RW]))
    else $error("customer source not routed to relay");

endmodule : dimgr_top

// file: verif/dimgr_plant.sv
// Purpose : Plant side model: field contacts and remote write master
// Assumes : Requests from the bench change just after a clock edge
// Notes   : A dead link shows the inverse of the last value sent
`timescale 1ns/1ps

module dimgr_plant
  import dimgr_pkg::*;
(
  input  wire logic              clock,
  input  wire logic [NUM_IN-1:0] contact,
  input  wire logic [NUM_IN-1:0] wr_val,
  input  wire logic              link_up,
  output logic      [NUM_IN-1:0] field_in,
  output logic      [NUM_IN-1:0] remote_val,
  output logic                   link_ok
);
  logic [NUM_IN-1:0] last_ff;

  // ****************************************
  // Contacts and link
  // ****************************************
  // Contacts are wired straight to the pins
  assign field_in = contact;
  assign link_ok  = link_up;

  // Remember what was sent while the link was up
  always_ff @(posedge clock)
  begin
    if (link_up)
    begin
      last_ff <= wr_val;
    end
  end

  // Lost link: lines carry junk, so a hold must not follow them
  assign remote_val = link_up ? wr_val : ~last_ff;
endmodule : dimgr_plant

// file: verif/dimgr_test.sv
// Purpose : Self-checking bench for the discrete I/O manager
// Assumes : Refresh tick of TK cycles stands in for 10 ms
// Notes   : Outputs are sampled 1 ns after the clock edge
`timescale 1ns/1ps

module dimgr_test
  import dimgr_pkg::*;
;
  localparam int TK = 8;
  logic                          clock = 1'b0;
  logic                          nrst = 1'b0;
  logic [NUM_IN-1:0]             contact, pol_high, wr_val, remote_en;
  logic [NUM_IN-1:0]             field_in, remote_val, in_status;
  logic                          link_up, link_ok, horn_mode;
  logic                          ctrl_healthy, ctrl_shutdown, ctrl_alarm;
  logic [NUM_FIXED-1:0]          cust_use;
  logic [NUM_CFG_IN-1:0][1:0]    fn_sel;
  logic [NUM_SEL_OUT-1:0][5:0]   out_sel;
  logic [NUM_CTRL_FN-1:0]        ctrl_func;
  logic [NUM_OUT-1:0]            relay_out;
  dimgr_cmd_t                    cmd;
  int                            num_errors = 0;
  int                            num_checks = 0;
  int                            cyc = 0;

  // ****************************************
  // Clock, instances, watchdog
  // ****************************************
  // Free running 100 MHz clock
  always #5 clock = ~clock;

  dimgr_top #(.TICK_CYC(TK)) i_dimgr_top (.clock(clock), .nrst(nrst),
    .field_in(field_in), .pol_high(pol_high), .remote_val(remote_val),
    .remote_en(remote_en), .link_ok(link_ok), .cust_use(cust_use),
    .fn_sel(fn_sel), .horn_mode(horn_mode), .out_sel(out_sel),
    .ctrl_func(ctrl_func), .ctrl_healthy(ctrl_healthy),
    .ctrl_shutdown(ctrl_shutdown), .ctrl_alarm(ctrl_alarm),
    .in_status(in_status), .cmd(cmd), .relay_out(relay_out));

  dimgr_plant i_dimgr_plant (.clock(clock), .contact(contact), .wr_val(wr_val),
    .link_up(link_up), .field_in(field_in), .remote_val(remote_val),
    .link_ok(link_ok));

  // Cut a hang short; the whole run needs well under a thousand cycles
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  // Bounded wait for one relay level, giving the cycle it was seen
  task automatic wait_rel(input int i, input logic v, input int lim, output int t);
    int n;
    n = 0;
    while (relay_out[i] !== v && n < lim)
    begin
      step(1);
      n++;
    end
    t = cyc;
    check(relay_out[i], v);
  endtask : wait_rel

  task automatic tally_and_finish();
    if (num_errors == 0 && num_checks > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  // ****************************************
  // Scenarios
  // ****************************************
  // Three flop latency and polarity flip
  task automatic t_inputs();
    @(posedge clock);
    contact[5] <= 1'b1;
    pol_high[6] <= 1'b0;
    step(2);
    check(in_status[5], 1'b0);
    step(1);
    check(in_status[6:5], 2'b11);
    @(posedge clock);
    contact[5] <= 1'b0;
    pol_high[6] <= 1'b1;
  endtask : t_inputs

  // Remote OR, its enable, and link loss hold or clear
  task automatic t_remote();
    @(posedge clock);
    wr_val <= 24'h000423;
    remote_en <= 24'h000403;
    step(3);
    check(in_status, 24'h000403);
    @(posedge clock);
    remote_en <= 24'h000423;
    step(3);
    check(in_status, 24'h000423);
    @(posedge clock);
    link_up <= 1'b0;
    step(4);
    check(in_status, 24'h000403);
    @(posedge clock);
    link_up <= 1'b1;
    wr_val <= 24'h0;
    remote_en <= 24'h0;
  endtask : t_remote

  // Default duty decode of dedicated and named inputs
  task automatic t_decode();
    @(posedge clock);
    contact <= 24'h00650d;
    step(4);
    check({cmd.fuel_off, cmd.start_run, cmd.sys_reset, cmd.sys_ack}, 4'h3);
    check({cmd.liquid_fuel, cmd.load_share_en}, 2'b11);
    check({cmd.rated_hold, cmd.baseload}, 2'b01);
    @(posedge clock);
    contact <= 24'h00450c;
    step(4);
    check({cmd.rated_hold, cmd.baseload, cmd.fuel_off}, 3'b101);
    @(posedge clock);
    cust_use <= 3'h1;
    step(1);
    check(cmd.fuel_off, 1'b0);
    @(posedge clock);
    cust_use <= 3'h0;
    contact <= 24'h000001;
  endtask : t_decode

  // Permissive, shutdown and alarm functions on inputs six to eight
  task automatic t_func();
    @(posedge clock);
    fn_sel[4:2] <= {FN_ALARM, FN_SHUTDOWN, FN_PERMISSIVE};
    step(4);
    check({cmd.permissive_ok, cmd.shutdown_any, cmd.alarm_any}, 3'b000);
    @(posedge clock);
    contact[7:5] <= 3'b111;
    step(4);
    check({cmd.permissive_ok, cmd.shutdown_any, cmd.alarm_any}, 3'b111);
    @(posedge clock);
    fn_sel <= '0;
    contact[7:5] <= 3'b000;
  endtask : t_func

  // Shutdown relay, rate groups and source selection
  task automatic t_relay();
    int tm, ts, t2;
    ctrl_healthy <= 1'b1;
    step(TK + 6);
    check(relay_out[0], 1'b1);
    @(posedge clock);
    ctrl_shutdown <= 1'b1;
    step(TK + 2);
    check(relay_out[0], 1'b0);
    @(posedge clock);
    ctrl_shutdown <= 1'b0;
    out_sel <= {NUM_SEL_OUT{6'h01}};
    ctrl_func <= 30'h1;
    wait_rel(6, 1'b1, 5 * TK, tm);
    check(relay_out[8:6], 3'b111);
    @(posedge clock);
    ctrl_func <= 30'h0;
    wait_rel(6, 1'b0, 5 * TK, t2);
    check(t2 - tm, 4 * TK);
    @(posedge clock);
    ctrl_func <= 30'h1;
    wait_rel(9, 1'b1, 17 * TK, ts);
    @(posedge clock);
    ctrl_func <= 30'h0;
    wait_rel(2, 1'b0, TK + 1, t2);
    wait_rel(9, 1'b0, 17 * TK, t2);
    check(t2 - ts, 16 * TK);
    @(posedge clock);
    out_sel <= {{4{6'h1e}}, 6'h00, 6'h23, 6'h22, 6'h21, 6'h20, 6'h1f};
    ctrl_func <= 30'h3fffffff;
    wr_val <= 24'h500000;
    remote_en <= 24'hf00000;
    step(17 * TK + 2);
    check(relay_out[11:2], 10'h3c5);
  endtask : t_relay

  // Alarm relay in summary and horn modes
  task automatic t_alarm();
    @(posedge clock);
    ctrl_alarm <= 1'b1;
    step(TK + 3);
    check(relay_out[1], 1'b1);
    @(posedge clock);
    ctrl_alarm <= 1'b0;
    step(TK + 3);
    check(relay_out[1], 1'b0);
    @(posedge clock);
    horn_mode <= 1'b1;
    ctrl_alarm <= 1'b1;
    step(TK + 3);
    check(relay_out[1], 1'b1);
    @(posedge clock);
    contact[3] <= 1'b1;
    step(TK + 6);
    check(relay_out[1], 1'b0);
    @(posedge clock);
    contact[3] <= 1'b0;
    step(TK + 2);
    check(relay_out[1], 1'b0);
    @(posedge clock);
    ctrl_alarm <= 1'b0;
    step(2);
    @(posedge clock);
    ctrl_alarm <= 1'b1;
    step(TK + 3);
    check(relay_out[1], 1'b1);
  endtask : t_alarm

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    contact = '0;
    pol_high = '1;
    wr_val = '0;
    remote_en = '0;
    link_up = 1'b1;
    cust_use = '0;
    fn_sel = '0;
    horn_mode = 1'b0;
    out_sel = '0;
    ctrl_func = '0;
    ctrl_healthy = 1'b0;
    ctrl_shutdown = 1'b0;
    ctrl_alarm = 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    step(1);
    check(in_status, 24'h0);
    check(relay_out, 12'h000);
    check({cmd.fuel_off, cmd.permissive_ok, cmd.shutdown_any}, 3'b111);
    t_inputs();
    t_remote();
    t_decode();
    t_func();
    t_relay();
    t_alarm();
    tally_and_finish();
  end
endmodule : dimgr_test
